/* include/sacs_pkg.sv */
// Package of constants and types for the SAR conversion sequencer
package sacs_pkg;
  // Result width: 12 bits plus sign
  localparam int unsigned RES_W = 13;
  // Frame length in serial clocks
  localparam logic [4:0] FRAME_CLKS = 5'h10;
  // Rising serial edge that returns the stage to tracking
  localparam logic [4:0] TRACK_EDGE = 5'h0E;
  // Number of codes per range
  localparam int unsigned NUM_CODES = 8192;
  // Control register payload width (bits after write flag and selects)
  localparam int unsigned CTRL_W = 12;
  // Register select value of the control register
  localparam logic [1:0] SEL_CTRL = 2'h0;
  // Control field positions within the 12-bit payload
  localparam int unsigned CTRL_MODE_LO = 8;
  localparam int unsigned CTRL_REF_POS = 2;
  localparam int unsigned CTRL_CODING_POS = 5;
  // Values after reset
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic CODING_RST = 1'b0;
  localparam logic REF_RST = 1'b0;
  // LSB sizes in microvolts per range code
  localparam int unsigned LSB_UV_10 = 2441;
  localparam int unsigned LSB_UV_5 = 1220;
  localparam int unsigned LSB_UV_2P5 = 610;
  // Host timing, for reference by the bench
  localparam int unsigned ACQ_MIN_NS = 305;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
  // Input pairing modes
  typedef enum logic [1:0] {
    SACS_SINGLE = 2'h0,
    SACS_PSEUDO4 = 2'h1,
    SACS_TRUEDIFF = 2'h2,
    SACS_PSEUDO7 = 2'h3
  } sacs_mode_t;
  // Frame sequencer states
  typedef enum logic [1:0] {
    SACS_IDLE,
    SACS_HOLD,
    SACS_TRACK
  } sacs_state_t;
endpackage

/* core/sacs_edge.sv */
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/100ps
`default_nettype none
module sacs_edge (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  // State: two sync stages and the previous synced level
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sacs_edge_st_t;
  sacs_edge_st_t st_r;
  sacs_edge_st_t st_nxt;
  // Shift chain; only s2 feeds s3
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end
  // Register the chain
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign level_o = st_r.s2;
  assign rise_o = st_r.s2 & ~st_r.s3;
  assign fall_o = ~st_r.s2 & st_r.s3;
endmodule // sacs_edge
`default_nettype wire

/* core/sacs_core.sv */
// SAR conversion sequencer driven by the host serial clock
`timescale 1ns/100ps
`default_nettype none
module sacs_core
  import sacs_pkg::*;
#(
  parameter int unsigned RW = sacs_pkg::RES_W
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic cmp_hi_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic track_o,
  output logic [RW-1:0] dac_code_o,
  output logic conv_done_o,
  output logic [RW-1:0] result_o,
  output logic [1:0] mode_o,
  output logic int_ref_o,
  output logic coding_bin_o,
  output logic [sacs_pkg::CTRL_W-1:0] ctrl_o
);
  import sacs_pkg::*;
  // Synchronised pin levels and edges
  logic sclk_lvl, sclk_rise, sclk_fall;
  logic cs_lvl, cs_rise, cs_fall;
  logic din_lvl;
  logic cmp_lvl;
  // All state of the block in one struct
  typedef struct packed {
    sacs_state_t st;
    logic [4:0] edges;        // Rising serial edges in this frame
    logic [RW-1:0] sar;       // Trial register
    logic [RW-1:0] trial;     // One-hot bit under trial
    logic [RW-1:0] res;       // Coded result being shifted out
    logic [14:0] shin;        // First fifteen frame bits; the last comes straight from the pin
    logic [CTRL_W-1:0] ctrl;  // Control register
    logic track;
    logic done;
    logic dout;
    logic oe;
  } sacs_core_st_t;
  sacs_core_st_t s_r;
  sacs_core_st_t s_nxt;
  // Pins come from outside the clock domain: two flops each
  sacs_edge u_sclk (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(sclk_i),
    .level_o(sclk_lvl), .rise_o(sclk_rise), .fall_o(sclk_fall));
  sacs_edge u_cs (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(cs_n_i),
    .level_o(cs_lvl), .rise_o(cs_rise), .fall_o(cs_fall));
  sacs_edge u_din (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(din_i),
    .level_o(din_lvl), .rise_o(), .fall_o());
  sacs_edge u_cmp (.mclk_i(mclk_i), .srst_i(srst_i), .pin_i(cmp_hi_i),
    .level_o(cmp_lvl), .rise_o(), .fall_o());
  // Coding of a finished SAR word
  function automatic logic [RW-1:0] code_fn(input logic [RW-1:0] tc, input logic bin);
    logic [RW-1:0] r;
    r = tc;
    if (bin) begin
      r[RW-1] = ~tc[RW-1];
    end
    return r;
  endfunction
  // Next-state logic of the sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      SACS_IDLE, SACS_TRACK: begin
        s_nxt.oe = 1'b0;
        if (cs_fall) begin
          // Sample frozen, new conversion begins
          s_nxt.st = SACS_HOLD;
          s_nxt.track = 1'b0;
          s_nxt.edges = '0;
          s_nxt.sar = '0;
          s_nxt.sar[RW-1] = 1'b1;
          s_nxt.trial = '0;
          s_nxt.trial[RW-1] = 1'b1;
          s_nxt.shin = '0;
          s_nxt.oe = 1'b1;
          // Leading zero ahead of the previous result
          s_nxt.dout = 1'b0;
        end
      end
      SACS_HOLD: begin
        if (cs_rise) begin
          // Frame abandoned early: back to tracking, no write
          s_nxt.st = SACS_IDLE;
          s_nxt.track = 1'b1;
          s_nxt.oe = 1'b0;
        end else if (sclk_rise) begin
          // Serial clock steps the SAR and samples input
          s_nxt.edges = s_r.edges + 5'h01;
          s_nxt.shin = {s_r.shin[13:0], din_lvl};
          if (s_r.trial != '0) begin
            // Comparator high means DAC above input: drop the bit
            if (cmp_lvl) begin
              s_nxt.sar = s_r.sar & ~s_r.trial;
            end
            s_nxt.trial = s_r.trial >> 1;
            if (s_r.trial[0]) begin
              // Last trial: result ready, coded with the stored control bit, not this frame's
              // Codes count whole LSBs; the LSB weight is set by the analog range
              s_nxt.res = code_fn({s_r.sar[RW-1:1], ~cmp_lvl}, s_r.ctrl[CTRL_CODING_POS]) ^
                {1'b1, {(RW-1){1'b0}}};
              s_nxt.done = 1'b1;
            end else begin
              s_nxt.sar = (cmp_lvl ? (s_r.sar & ~s_r.trial) : s_r.sar) | (s_r.trial >> 1);
            end
          end
          if (s_r.edges + 5'h01 == TRACK_EDGE) begin
            s_nxt.track = 1'b1;
          end
          if (s_r.edges + 5'h01 == FRAME_CLKS) begin
            s_nxt.st = SACS_TRACK;
            s_nxt.oe = 1'b0;
            // Write flag and select gate the load
            if (s_r.shin[14] && s_r.shin[13:12] == SEL_CTRL) begin
              s_nxt.ctrl = {s_r.shin[10:0], din_lvl};
            end
          end
        end else if (sclk_fall && s_r.trial != '0) begin
          // Previous result shifts out MSB first on the first 13 falls,
          // so a fresh result is never half shifted before its own frame
          s_nxt.dout = s_r.res[RW-1];
          s_nxt.res = {s_r.res[RW-2:0], 1'b0};
        end
      end
      default: begin
        s_nxt.st = SACS_IDLE;
      end
    endcase
  end
  // Register the whole state
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_r.st <= SACS_IDLE;
      s_r.edges <= '0;
      s_r.sar <= '0;
      s_r.trial <= '0;
      s_r.res <= '0;
      s_r.shin <= '0;
      // Twos complement, single-ended, external ref
      s_r.ctrl <= '0;
      s_r.track <= 1'b1;
      s_r.done <= 1'b0;
      s_r.dout <= 1'b0;
      s_r.oe <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // Outputs straight from state flops
  assign dout_o = s_r.dout;
  assign dout_oe_o = s_r.oe;
  assign track_o = s_r.track;
  assign dac_code_o = s_r.sar;
  assign conv_done_o = s_r.done;
  assign result_o = s_r.res;
  assign mode_o = s_r.ctrl[CTRL_MODE_LO+1:CTRL_MODE_LO];
  assign int_ref_o = s_r.ctrl[CTRL_REF_POS];
  assign coding_bin_o = s_r.ctrl[CTRL_CODING_POS];
  assign ctrl_o = s_r.ctrl;
endmodule // sacs_core
`default_nettype wire

/* dv/sacs_host.sv */
// Serial host model that frames words into the sequencer
`timescale 1ns/100ps
`default_nettype none
module sacs_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  // Idle: clock parked high, select released
  initial begin
    sclk_o = 1'h1;
    cs_n_o = 1'h1;
    din_o = 1'h0;
  end
  // One 16-clock frame, MSB first, 400 ns clock
  task automatic frame(input logic [15:0] w);
    cs_n_o = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      #100 sclk_o = 1'h0;
      din_o = w[i];
      #200 sclk_o = 1'h1;
      #100;
    end
    #100 cs_n_o = 1'h1;
    // Released line must not keep the last bit
    din_o = ~din_o;
    // Tracking gap well above 305 ns
    #600;
  endtask
endmodule // sacs_host
`default_nettype wire

/* dv/sacs_core_sva.sv */
// Port assertions for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module sacs_core_sva
  import sacs_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic cs_n_i,
  input wire logic track_o,
  input wire logic conv_done_o,
  input wire logic dout_oe_o,
  input wire logic [1:0] mode_o,
  input wire logic int_ref_o,
  input wire logic coding_bin_o,
  input wire logic [CTRL_W-1:0] ctrl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  rst_state_a: assert property ($fell(srst_i) |-> track_o && ctrl_o == 12'h000) else $error("reset state");
  hold_start_a: assert property ($fell(cs_n_i) |-> ##[2:6] !track_o) else $error("no hold");
  hold_len_a: assert property ($fell(track_o) |-> !track_o [*8]) else $error("hold short");
  done_pulse_a: assert property (conv_done_o |=> !conv_done_o) else $error("done width");
  done_hold_a: assert property (conv_done_o |-> !track_o && dout_oe_o) else $error("done in track");
  mode_fld_a: assert property (mode_o == ctrl_o[9:8]) else $error("mode field");
  code_fld_a: assert property (coding_bin_o == ctrl_o[5]) else $error("coding field");
  ref_fld_a: assert property (int_ref_o == ctrl_o[2]) else $error("ref field");
  ctrl_hold_a: assert property (!dout_oe_o |=> $stable(ctrl_o)) else $error("ctrl moved");
  oe_start_a: assert property ($rose(dout_oe_o) |-> !track_o) else $error("frame in track");
  oe_end_a: assert property ($fell(dout_oe_o) |-> track_o) else $error("frame end in hold");
endmodule // sacs_core_sva
bind sacs_core sacs_core_sva i_sva (.mclk_i, .srst_i, .cs_n_i, .track_o, .conv_done_o, .dout_oe_o,
  .mode_o, .int_ref_o, .coding_bin_o, .ctrl_o);
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sacs_pkg::*;
  logic mclk_i, srst_i, sclk, cs_n, din, track, done, bin, iref, dout, oe;
  logic [1:0] mode;
  logic [11:0] ctrl, exp_ctrl;
  logic [12:0] dac, res, vin, prev_res;
  int bad_count = 0, num_checks = 0, cyc = 0;
  // Comparator: trial above held input clears the bit
  wire logic cmp_hi = dac > vin;
  sacs_core i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .cmp_hi_i(cmp_hi), .dout_o(dout), .dout_oe_o(oe), .track_o(track), .dac_code_o(dac),
    .conv_done_o(done), .result_o(res), .mode_o(mode), .int_ref_o(iref), .coding_bin_o(bin), .ctrl_o(ctrl));
  sacs_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din));
  // Compare and count
  task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One frame with held input v; coding in force is the pre-load one
  task automatic run(input logic [15:0] w, input logic [12:0] v);
    logic [12:0] e;
    logic [12:0] got;
    int n;
    @(negedge mclk_i);
    vin = v;
    got = 13'h0000;
    e = exp_ctrl[5] ? v : {~v[12], v[11:0]};
    fork
      i_host.frame(w);
      begin
        n = 0;
        // Bounded wait for the end of the trials
        while (done !== 1'h1 && n < 400) begin
          @(negedge mclk_i);
          n++;
        end
        check("done", {12'h000, done}, 13'h0001);
        check("hold", {12'h000, track}, 13'h0000);
        check("frame_oe", {12'h000, oe}, 13'h0001);
        check("result", res, e);
      end
      begin
        // Previous result, MSB first, taken on host clock rises
        repeat (13) begin
          @(posedge sclk);
          got = {got[11:0], dout};
        end
        check("dout", got, prev_res);
      end
    join
    prev_res = e;
    check("idle_oe", {12'h000, oe}, 13'h0000);
    // Only write flag with select 0 loads control
    if (w[15:13] == 3'h4) exp_ctrl = w[11:0];
    check("ctrl", {1'h0, ctrl}, {1'h0, exp_ctrl});
    check("mode", {11'h000, mode}, {11'h000, exp_ctrl[9:8]});
    check("coding", {12'h000, bin}, {12'h000, exp_ctrl[5]});
    check("ref", {12'h000, iref}, {12'h000, exp_ctrl[2]});
    check("track", {12'h000, track}, 13'h0001);
  endtask
  // Defaults straight out of reset
  task automatic sc_reset;
    check("rst_ctrl", {1'h0, ctrl}, 13'h0000);
    check("rst_track", {12'h000, track}, 13'h0001);
    check("rst_oe", {12'h000, oe}, 13'h0000);
  endtask
  // Coding switch, ignored write, other register select
  task automatic sc_coding;
    run(16'h8000, 13'h0005);
    run(16'h8224, 13'h1FFF);
    run(16'h0FFF, 13'h0000);
    run(16'hAFFF, 13'h1000);
  endtask
  // Every pairing mode
  task automatic sc_modes;
    for (int m = 0; m < 4; m++) begin
      run({4'h8, 2'h0, 2'(m), 8'h00}, 13'(m * 1000));
    end
  endtask
  // Counts then verdict
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    mclk_i = 1'h0;
    forever #25 mclk_i = ~mclk_i;
  end
  // Hang guard, far above eight frames
  always @(negedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    srst_i = 1'h1;
    vin = 13'h0000;
    prev_res = 13'h0000;
    exp_ctrl = 12'h000;
    repeat (10) @(negedge mclk_i);
    srst_i = 1'h0;
    repeat (3) @(negedge mclk_i);
    sc_reset();
    sc_coding();
    sc_modes();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
